/* File: src/qdu_consts.vh */
`ifndef QDU_CONSTS_VH
`define QDU_CONSTS_VH
// Frame layout: 24 bits, MSB first: [23] read, [22:19] command, [18:16] channel, [15:0] data
`define QDU_FRAME_BITS 24
`define QDU_DATA_BITS 16
`define QDU_BIT_READ 23
`define QDU_CMD_HI 22
`define QDU_CMD_LO 19
`define QDU_CH_HI 18
`define QDU_CH_LO 16
// Command codes
`define QDU_CMD_NOP 4'h0
`define QDU_CMD_DATA 4'h2
`define QDU_CMD_CTRL 4'h1
// Control data fields
`define QDU_CTL_DAISY 0
`define QDU_CTL_DIR0 1
`define QDU_CTL_DIR1 2
`define QDU_CTL_OUT0 3
`define QDU_CTL_OUT1 4
// Channel selector meaning all channels
`define QDU_CH_ALL 3'h4
// Reset values and the clear code
`define QDU_DATA_RST 16'h0000
`define QDU_CLEAR_CODE 16'h0000
`define QDU_CTL_RST 5'h00
// Serial clock limit and the link clock in the bench
`define QDU_SCLK_MAX_MHZ 30
`define QDU_CLK_MHZ 100
`endif

/* File: src/qdu_buf2.v */
`timescale 1ns/10ps
// Two-entry skid buffer; the sink may stall, source sees in_ready drop when full
module qdu_buf2 #(
	parameter WIDTH = 24
)(
	clk,
	srst,
	in_valid,
	in_ready,
	in_data,
	out_valid,
	out_ready,
	out_data
);
	input wire clk;
	input wire srst;
	input wire in_valid;
	output wire in_ready;
	input wire [WIDTH-1:0] in_data;
	output wire out_valid;
	input wire out_ready;
	output wire [WIDTH-1:0] out_data;

	reg [WIDTH-1:0] mem_r [0:1];
	reg wptr_r;
	reg rptr_r;
	reg [1:0] cnt_r;
	wire push;
	wire pop;

	assign in_ready = (cnt_r != 2'd2);
	assign out_valid = (cnt_r != 2'd0);
	assign out_data = mem_r[rptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk)
	begin
		if (srst)
		begin
			wptr_r <= 1'b0;
			rptr_r <= 1'b0;
			cnt_r <= 2'd0;
		end
		else
		begin
			if (push)
				wptr_r <= ~wptr_r;
			if (pop)
				rptr_r <= ~rptr_r;
			if (push & ~pop)
				cnt_r <= cnt_r + 2'd1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 2'd1;
		end
	end

	always @(posedge clk)
	begin
		if (push)
			mem_r[wptr_r] <= in_data;
	end
endmodule

/* File: src/qdu_serial_update.v */
`timescale 1ns/10ps
`include "qdu_consts.vh"
module qdu_serial_update #(
	parameter CHANNELS = 4
)(
	clk,
	srst,
	sclk,
	frame_sel_n,
	serial_data_in,
	serial_data_out,
	clear_to_zero_n,
	load_update_n,
	gpio_bit0_in,
	gpio_bit0_out,
	gpio_bit0_oe_n,
	gpio_bit1_in,
	gpio_bit1_out,
	gpio_bit1_oe_n,
	reset_clamp_in_n,
	supply_ok,
	supply_monitor_out,
	coding_select,
	dac_code,
	dac_clamp,
	dac_valid,
	dac_ready
);
	input wire clk;
	input wire srst;
	input wire sclk;
	input wire frame_sel_n;
	input wire serial_data_in;
	output reg serial_data_out;
	input wire clear_to_zero_n;
	input wire load_update_n;
	input wire gpio_bit0_in;
	output reg gpio_bit0_out;
	output reg gpio_bit0_oe_n;
	input wire gpio_bit1_in;
	output reg gpio_bit1_out;
	output reg gpio_bit1_oe_n;
	input wire reset_clamp_in_n;
	input wire supply_ok;
	output reg supply_monitor_out;
	input wire coding_select;
	output reg [`QDU_DATA_BITS*CHANNELS-1:0] dac_code;
	output reg dac_clamp;
	output reg dac_valid;
	input wire dac_ready;

	localparam NPIN = 9;
	localparam W = `QDU_FRAME_BITS;
	localparam DW = `QDU_DATA_BITS;

	// Three-stage synchronisers; a change counts when stages 2 and 3 agree
	reg [NPIN-1:0] s1_r;
	reg [NPIN-1:0] s2_r;
	reg [NPIN-1:0] s3_r;
	reg [NPIN-1:0] st_r;
	wire [NPIN-1:0] pins;
	assign pins = {supply_ok, coding_select, reset_clamp_in_n, gpio_bit1_in, gpio_bit0_in,
		load_update_n, clear_to_zero_n, frame_sel_n, sclk};
	always @(posedge clk)
	begin
		if (srst)
		begin
			s1_r <= {NPIN{1'b1}};
			s2_r <= {NPIN{1'b1}};
			s3_r <= {NPIN{1'b1}};
			st_r <= {NPIN{1'b1}};
		end
		else
		begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			st_r <= (s2_r & s3_r) | (st_r & (s2_r ^ s3_r));
		end
	end

	reg [NPIN-1:0] stp_r;
	always @(posedge clk)
	begin
		if (srst)
			stp_r <= {NPIN{1'b1}};
		else
			stp_r <= st_r;
	end
	wire sclk_fall = stp_r[0] & ~st_r[0];
	wire sclk_rise = ~stp_r[0] & st_r[0];
	wire fs_n = st_r[1];
	wire fs_rise = ~stp_r[1] & st_r[1];
	wire clr_fall = stp_r[2] & ~st_r[2];
	wire ldu_n = st_r[3];
	wire ldu_fall = stp_r[3] & ~st_r[3];

	// Serial data passes a three-flop delay (sd_r[2]) and is sampled at the falling edge detection; it sits still by then
	reg [2:0] sd_r;
	always @(posedge clk)
	begin
		if (srst)
			sd_r <= 3'h0;
		else
			sd_r <= {sd_r[1:0], serial_data_in};
	end

	reg [W-1:0] shift_r;
	reg [4:0] nbits_r;
	reg [W-1:0] rdback_r;
	reg rd_pend_r;
	reg [4:0] ctl_r;
	reg [DW*CHANNELS-1:0] inreg_r;
	reg [DW*CHANNELS-1:0] datreg_r;
	reg upd_pend_r;
	// Pulses once the readback word is ready; the host must leave frame select
	// high for a few clocks after a read frame or the next frame misses it
	reg rd_ld_r;

	// Frame capture feeds the two-entry buffer; its out_ready is tied high, so the buffer
	// drains every clock, never fills, and drops no frame at frame end
	wire bin_ready;
	wire bout_valid;
	wire [W-1:0] bout_data;
	wire frame_done = fs_rise & (nbits_r >= 5'd24);
	qdu_buf2 #(.WIDTH(W)) u_buf (
		.clk(clk),
		.srst(srst),
		.in_valid(frame_done),
		.in_ready(bin_ready),
		.in_data(shift_r),
		.out_valid(bout_valid),
		.out_ready(1'b1),
		.out_data(bout_data)
	);

	function [DW-1:0] qdu_code;
		input [DW-1:0] d;
		input bin;
		begin
			qdu_code = bin ? d : (d ^ 16'h8000);
		end
	endfunction

	always @(posedge clk)
	begin
		if (srst)
		begin
			shift_r <= {W{1'b0}};
			nbits_r <= 5'd0;
		end
		else if (fs_n)
		begin
			nbits_r <= 5'd0;
			if (rd_ld_r)
				shift_r <= rdback_r;
		end
		else if (sclk_fall)
		begin
			shift_r <= {shift_r[W-2:0], sd_r[2]};
			if (nbits_r != 5'd31)
				nbits_r <= nbits_r + 5'd1;
		end
	end

	wire [3:0] cmd = bout_data[`QDU_CMD_HI:`QDU_CMD_LO];
	wire [2:0] ch = bout_data[`QDU_CH_HI:`QDU_CH_LO];
	wire [DW-1:0] dat = bout_data[DW-1:0];
	wire isrd = bout_data[`QDU_BIT_READ];
	integer i;
	integer j;

	always @(posedge clk)
	begin
		if (srst)
		begin
			ctl_r <= `QDU_CTL_RST;
			inreg_r <= {CHANNELS{`QDU_DATA_RST}};
			datreg_r <= {CHANNELS{`QDU_DATA_RST}};
			upd_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			rd_ld_r <= 1'b0;
			rdback_r <= {W{1'b0}};
		end
		else
		begin
			rd_ld_r <= bout_valid & isrd;
			if (fs_rise)
				rd_pend_r <= 1'b0;
			if (bout_valid & isrd)
			begin
				rd_pend_r <= 1'b1;
				rdback_r <= {1'b0, cmd, ch, {DW{1'b0}}};
				if (cmd == `QDU_CMD_CTRL)
					rdback_r[6:0] <= {st_r[5], st_r[4], ctl_r};
				else if (ch < CHANNELS)
					rdback_r[DW-1:0] <= inreg_r[ch*DW +: DW];
			end
			else if (bout_valid & (cmd == `QDU_CMD_CTRL))
				ctl_r <= dat[4:0];
			else if (bout_valid & (cmd == `QDU_CMD_DATA))
			begin
				for (i = 0; i < CHANNELS; i = i + 1)
					if (ch == i[2:0] || ch == `QDU_CH_ALL)
					begin
						inreg_r[i*DW +: DW] <= dat;
						if (!ldu_n)
							datreg_r[i*DW +: DW] <= dat;
					end
				if (ldu_n)
					upd_pend_r <= 1'b1;
			end
			if (ldu_fall)
			begin
				datreg_r <= inreg_r;
				upd_pend_r <= 1'b0;
			end
			if (clr_fall)
				datreg_r <= {CHANNELS{`QDU_CLEAR_CODE}};
		end
	end

	reg [DW*CHANNELS-1:0] codes;
	always @*
	begin
		codes = {DW*CHANNELS{1'b0}};
		for (j = 0; j < CHANNELS; j = j + 1)
			codes[j*DW +: DW] = qdu_code(datreg_r[j*DW +: DW], st_r[7]);
	end

	always @(posedge clk)
	begin
		if (srst)
		begin
			serial_data_out <= 1'b0;
			gpio_bit0_out <= 1'b0;
			gpio_bit1_out <= 1'b0;
			gpio_bit0_oe_n <= 1'b1;
			gpio_bit1_oe_n <= 1'b1;
			supply_monitor_out <= 1'b0;
			dac_code <= {DW*CHANNELS{1'b0}};
			dac_clamp <= 1'b1;
			dac_valid <= 1'b0;
		end
		else
		begin
			if ((ctl_r[`QDU_CTL_DAISY] | rd_pend_r) & sclk_rise & ~fs_n)
				serial_data_out <= shift_r[W-1];
			else if (rd_ld_r)
				serial_data_out <= rdback_r[W-1];
			else if (fs_rise)
				serial_data_out <= ctl_r[`QDU_CTL_DAISY] ? shift_r[W-1] : 1'b0;
			gpio_bit0_oe_n <= ~ctl_r[`QDU_CTL_DIR0];
			gpio_bit1_oe_n <= ~ctl_r[`QDU_CTL_DIR1];
			gpio_bit0_out <= ctl_r[`QDU_CTL_OUT0];
			gpio_bit1_out <= ctl_r[`QDU_CTL_OUT1];
			supply_monitor_out <= st_r[8];
			dac_clamp <= ~st_r[6];
			if (dac_valid & ~dac_ready)
				dac_valid <= 1'b1;
			else
			begin
				dac_valid <= 1'b1;
				dac_code <= codes;
			end
		end
	end
endmodule

/* File: tb/qdu_chk.sv */
`timescale 1ns/10ps
module qdu_chk(
	clk,
	srst,
	frame_sel_n,
	clear_to_zero_n,
	load_update_n,
	reset_clamp_in_n,
	supply_ok,
	supply_monitor_out,
	gpio_bit0_oe_n,
	gpio_bit1_oe_n,
	dac_code,
	dac_clamp,
	dac_valid,
	dac_ready,
	coding_select
);
	input wire coding_select;
	input wire clk, srst, frame_sel_n, clear_to_zero_n, load_update_n;
	input wire reset_clamp_in_n, supply_ok, supply_monitor_out, gpio_bit0_oe_n;
	input wire gpio_bit1_oe_n, dac_clamp, dac_valid, dac_ready;
	input wire [63:0] dac_code;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	a_clamp_on: assert property (!reset_clamp_in_n [*7] |-> dac_clamp)
		else $error("clamp not raised");
	a_clamp_off: assert property (reset_clamp_in_n [*7] |-> !dac_clamp)
		else $error("clamp not released");
	a_clear_zero: assert property ($fell(clear_to_zero_n) && coding_select && dac_ready
		|-> ##[1:20] dac_code == 64'h0)
		else $error("clear did not zero codes");
	a_idle_still: assert property ((frame_sel_n && clear_to_zero_n && dac_ready
		&& $stable(load_update_n)) [*8] ##1 (frame_sel_n && clear_to_zero_n && dac_ready
		&& $stable(load_update_n)) [*8] |-> $stable(dac_code)) else $error("code moved");
	a_load_update_n_defer: assert property ((load_update_n && clear_to_zero_n && dac_ready) [*8]
		##1 (load_update_n && clear_to_zero_n && dac_ready) [*8] |-> $stable(dac_code))
		else $error("code moved while load held off");
	a_monitor_copy: assert property ($stable(supply_ok) [*6] |-> supply_monitor_out == supply_ok)
		else $error("monitor output wrong");
	a_stall_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_code))
		else $error("code lost during stall");
	a_pins_input: assert property ($fell(srst) |-> gpio_bit0_oe_n && gpio_bit1_oe_n)
		else $error("pins not inputs after reset");
endmodule

/* File: tb/qdu_host.sv */
`timescale 1ns/10ps
module qdu_host(
	sclk,
	frame_sel_n,
	serial_data_in,
	serial_data_out
);
	output reg sclk;
	output reg frame_sel_n;
	output reg serial_data_in;
	input wire serial_data_out;
	initial
	begin
		sclk = 1'b1;
		frame_sel_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// Data changes while sclk is high; the returned word is sdo seen before each fall
	task send(input fr, input integer n, input [23:0] w, output [23:0] r);
		integer i;
		begin
			frame_sel_n = !fr;
			for (i = n - 1; i >= 0; i = i - 1)
			begin
				serial_data_in = w[i];
				#80 r = {r[22:0], serial_data_out};
				sclk = 1'b0;
				#80 sclk = 1'b1;
			end
			#80 frame_sel_n = 1'b1;
			serial_data_in = ~serial_data_in;
			#400;
		end
	endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg clear_to_zero_n = 1'b1;
	reg load_update_n = 1'b0;
	reg reset_clamp_in_n = 1'b1;
	reg supply_ok = 1'b1;
	reg coding_select = 1'b1;
	reg dac_ready = 1'b1;
	reg [23:0] rb;
	integer failures = 0;
	integer tests_run = 0;
	wire sclk, frame_sel_n, serial_data_in, serial_data_out, supply_monitor_out;
	wire gpio_bit0_out, gpio_bit0_oe_n, gpio_bit1_out, gpio_bit1_oe_n, dac_clamp, dac_valid;
	wire [63:0] dac_code;
	// Weak pull-ups hold the pins high whenever the block is not driving them
	wire gpio_bit0_in = gpio_bit0_oe_n ? 1'b1 : gpio_bit0_out;
	wire gpio_bit1_in = gpio_bit1_oe_n ? 1'b1 : gpio_bit1_out;
	always #5 clk = ~clk;
	qdu_host i_host(.sclk, .frame_sel_n, .serial_data_in, .serial_data_out);
	qdu_serial_update i_dut(.clk, .srst, .sclk, .frame_sel_n, .serial_data_in,
		.serial_data_out, .clear_to_zero_n, .load_update_n, .gpio_bit0_in, .gpio_bit0_out,
		.gpio_bit0_oe_n, .gpio_bit1_in, .gpio_bit1_out, .gpio_bit1_oe_n, .reset_clamp_in_n,
		.supply_ok, .supply_monitor_out, .coding_select, .dac_code, .dac_clamp, .dac_valid,
		.dac_ready);
	task tk(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp)
			begin
				failures = failures + 1;
				$display("FAIL %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [23:0] w);
		begin
			i_host.send(1'b1, 24, w, rb);
			tk(20);
		end
	endtask
	task t_imm;
		begin
			i_host.send(1'b0, 24, 24'h111234, rb);
			chk(dac_code, 64'h0);
			i_host.send(1'b1, 23, 24'h105555, rb);
			tk(20);
			chk(dac_code, 64'h0);
			wr(24'h111234);
			chk(dac_code[31:16], 16'h1234);
			coding_select = 1'b0;
			wr(24'h120001);
			chk(dac_code[47:32], 16'h8001);
			coding_select = 1'b1;
		end
	endtask
	task t_defer;
		begin
			load_update_n = 1'b1;
			wr(24'h14abcd);
			chk(dac_code[15:0], 16'h0);
			load_update_n = 1'b0;
			tk(20);
			chk(dac_code, {4{16'habcd}});
			clear_to_zero_n = 1'b0;
			tk(20);
			chk(dac_code, 64'h0);
			clear_to_zero_n = 1'b1;
		end
	endtask
	task t_clamp;
		begin
			wr(24'h1300ff);
			reset_clamp_in_n = 1'b0;
			tk(10);
			chk({dac_clamp, dac_code[63:48]}, 17'h100ff);
			reset_clamp_in_n = 1'b1;
			supply_ok = 1'b0;
			tk(10);
			chk({dac_clamp, supply_monitor_out}, 2'b00);
			supply_ok = 1'b1;
		end
	endtask
	task t_gpio;
		begin
			wr(24'h08000e);
			chk({gpio_bit0_oe_n, gpio_bit0_out, gpio_bit1_oe_n, gpio_bit1_out}, 4'h4);
			wr(24'h880000);
			wr(24'h000000);
			chk(rb[6:5], 2'b01);
			wr(24'h080001);
			wr(24'h5a5a5a);
			chk(rb, 24'h080001);
			wr(24'h080000);
			chk(rb, 24'h5a5a5a);
		end
	endtask
	task t_stall;
		begin
			dac_ready = 1'b0;
			wr(24'h104321);
			chk(dac_code[15:0], 16'h0);
			dac_ready = 1'b1;
			tk(20);
			chk(dac_code[15:0], 16'h4321);
			chk(dac_valid, 1'b1);
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d failures %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial
	begin
		tk(6);
		srst = 1'b0;
		tk(6);
		t_imm;
		t_defer;
		t_clamp;
		t_gpio;
		t_stall;
		give_verdict;
	end
	// Whole run needs about 60 us of frames; four times that means a hang
	initial
	begin
		#240000;
		failures = failures + 1;
		give_verdict;
	end
endmodule
bind qdu_serial_update qdu_chk i_chk(.clk, .srst, .frame_sel_n, .clear_to_zero_n,
	.load_update_n, .reset_clamp_in_n, .supply_ok, .supply_monitor_out, .gpio_bit0_oe_n,
	.gpio_bit1_oe_n, .dac_code, .dac_clamp, .dac_valid, .dac_ready, .coding_select);
